// *** logic/dpr_ram.sv ***
// Dual-port data RAM shared by the CPU data path and the DMA controller
module dpr_ram
    import dpr_pkg::*;
#(
    parameter int unsigned RAM_BYTES = DPR_RAM_BYTES,
    parameter logic [15:0] BASE_EA   = 16'hF800
)(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire dpr_req_type cpuReq,
    input  wire dpr_req_type dmaReq,
    output dpr_rsp_type      cpuRsp,
    output dpr_rsp_type      dmaRsp,
    output logic             collide
);

    localparam int unsigned WORDS = RAM_BYTES / 2;
    localparam int unsigned AW    = $clog2(WORDS);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks: size bounded, power of two, RAM ends at top
    if (RAM_BYTES > DPR_RAM_BYTES || RAM_BYTES < 4 ||
        (RAM_BYTES & (RAM_BYTES - 1)) != 0) begin : g_bad_size
        $error("dpr_ram: RAM_BYTES must be a power of two <= 2048");
    end
    if ({1'b0, BASE_EA} + 17'(RAM_BYTES) != DPR_SPACE_TOP) begin : g_bad_base
        $error("dpr_ram: RAM must end at the top of Y space");
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode inside the Y space window
    logic          cpuHit, dmaHit;
    logic [AW-1:0] cpuIdx, dmaIdx;

    assign cpuHit = cpuReq.sel && (cpuReq.ea >= BASE_EA);
    assign dmaHit = dmaReq.sel && (dmaReq.ea >= BASE_EA);
    assign cpuIdx = cpuReq.ea[AW:1];
    assign dmaIdx = dmaReq.ea[AW:1];

    // Per-lane write enables; byte writes pick a lane from ea[0]
    logic [1:0] cpuLane, dmaLane, dmaKeep;
    always_comb begin
        cpuLane = 2'h0;
        dmaLane = 2'h0;
        if (cpuHit && cpuReq.write) begin
            cpuLane = cpuReq.isByte ? (cpuReq.ea[0] ? 2'h2 : 2'h1)
                                    : 2'h3;
        end
        if (dmaHit && dmaReq.write) begin
            dmaLane = dmaReq.isByte ? (dmaReq.ea[0] ? 2'h2 : 2'h1)
                                    : 2'h3;
        end
        // DMA lanes also written by the CPU at the same word are dropped
        if (cpuIdx == dmaIdx)
            dmaKeep = dmaLane & ~cpuLane;
        else
            dmaKeep = dmaLane;
    end

    // Write data placed on the lane it targets
    logic [15:0] cpuWdata, dmaWdata;
    assign cpuWdata = cpuReq.isByte ? {2{cpuReq.wdata[7:0]}} : cpuReq.wdata;
    assign dmaWdata = dmaReq.isByte ? {2{dmaReq.wdata[7:0]}} : dmaReq.wdata;

    ////////////////////////////////////////////////////////////////////////
    // Storage: two byte lanes sharing one word index
    logic [15:0] mem_r [WORDS];
    logic [15:0] mem_nxt [WORDS];

    genvar gw;
    generate
        for (gw = 0; gw < WORDS; gw++) begin : g_word
            always_comb begin
                mem_nxt[gw] = mem_r[gw];
                for (int b = 0; b < 2; b++) begin
                    if (dmaKeep[b] && dmaIdx == AW'(gw)) begin
                        mem_nxt[gw][b*8 +: 8] = dmaWdata[b*8 +: 8];
                    end
                    if (cpuLane[b] && cpuIdx == AW'(gw)) begin
                        mem_nxt[gw][b*8 +: 8] = cpuWdata[b*8 +: 8];
                    end
                end
            end
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    mem_r[gw] <= DPR_DATA_RESET;
                end else begin
                    mem_r[gw] <= mem_nxt[gw];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read answers: each port reads independently, fixed one-cycle latency
    function automatic logic [15:0] pick(input dpr_req_type rq,
                                         input logic [15:0] word);
        logic [15:0] r;
        r = word;
        if (rq.isByte)
            r = {8'h00, rq.ea[0] ? word[15:8] : word[7:0]};
        return r;
    endfunction

    dpr_rsp_type cpuRsp_r, cpuRsp_nxt, dmaRsp_r, dmaRsp_nxt;
    logic        collide_r, collide_nxt;

    // Next answers, computed from the stored word before this cycle's write
    always_comb begin
        cpuRsp_nxt       = '0;
        dmaRsp_nxt       = '0;
        cpuRsp_nxt.hit   = cpuHit;
        dmaRsp_nxt.hit   = dmaHit;
        cpuRsp_nxt.valid = cpuReq.sel && !cpuReq.write;
        dmaRsp_nxt.valid = dmaReq.sel && !dmaReq.write;
        if (cpuHit)
            cpuRsp_nxt.rdata = pick(cpuReq, mem_r[cpuIdx]);
        if (dmaHit)
            dmaRsp_nxt.rdata = pick(dmaReq, mem_r[dmaIdx]);
        collide_nxt = (dmaLane != dmaKeep);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cpuRsp_r  <= '0;
            dmaRsp_r  <= '0;
            collide_r <= 1'b0;
        end else begin
            cpuRsp_r  <= cpuRsp_nxt;
            dmaRsp_r  <= dmaRsp_nxt;
            collide_r <= collide_nxt;
        end
    end

    assign cpuRsp  = cpuRsp_r;
    assign dmaRsp  = dmaRsp_r;
    assign collide = collide_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers, all on the one system clock
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // Helper: a DMA write lane overlaps a CPU write lane at one word
    logic laneClash;
    assign laneClash = (cpuIdx == dmaIdx) && (|(cpuLane & dmaLane));

    // A CPU word write wins a same-word collision
    cpu_wins_a: assert property (
        cpuHit && cpuReq.write && !cpuReq.isByte &&
        dmaHit && dmaReq.write && cpuIdx == dmaIdx
        |=> mem_r[$past(cpuIdx)] == $past(cpuReq.wdata))
        else $error("CPU write lost in collision");

    // The dropped DMA write is reported one cycle later
    dma_drop_a: assert property (
        cpuHit && cpuReq.write && !cpuReq.isByte &&
        dmaHit && dmaReq.write && cpuIdx == dmaIdx
        |=> collide)
        else $error("collision not flagged");

    // The flag never rises without a real lane overlap
    collide_only_a: assert property (
        collide |-> $past(laneClash))
        else $error("collision flagged without overlap");

    // A DMA word write to a different word than a CPU word write still lands
    both_write_a: assert property (
        cpuHit && cpuReq.write && !cpuReq.isByte &&
        dmaHit && dmaReq.write && !dmaReq.isByte && cpuIdx != dmaIdx
        |=> mem_r[$past(dmaIdx)] == $past(dmaReq.wdata))
        else $error("DMA write to other word lost");

    // Each port gets its read answer on the next edge, no wait states
    cpu_read_a: assert property (
        cpuHit && !cpuReq.write && !cpuReq.isByte
        |=> cpuRsp.valid && cpuRsp.rdata == $past(mem_r[cpuIdx]))
        else $error("CPU read wrong or late");

    dma_read_a: assert property (
        dmaHit && !dmaReq.write && !dmaReq.isByte
        |=> dmaRsp.valid && dmaRsp.rdata == $past(mem_r[dmaIdx]))
        else $error("DMA read wrong or late");

    // A CPU byte write leaves the other lane alone
    lane_keep_a: assert property (
        cpuHit && cpuReq.write && cpuReq.isByte && !(dmaHit && dmaReq.write)
        |=> (mem_r[$past(cpuIdx)][15:8] == $past(mem_r[cpuIdx][15:8]) ||
             $past(cpuReq.ea[0])) &&
            (mem_r[$past(cpuIdx)][7:0] == $past(mem_r[cpuIdx][7:0]) ||
             !$past(cpuReq.ea[0])))
        else $error("byte write touched other lane");

    // A lone DMA byte write lands on the lane that ea[0] picks
    dma_lane_a: assert property (
        dmaHit && dmaReq.write && dmaReq.isByte && !(cpuHit && cpuReq.write)
        |=> ($past(dmaReq.ea[0]) ? mem_r[$past(dmaIdx)][15:8]
                                 : mem_r[$past(dmaIdx)][7:0])
            == $past(dmaReq.wdata[7:0]))
        else $error("DMA byte write missed its lane");

    // Reads outside the RAM miss and return zero
    outside_miss_a: assert property (
        cpuReq.sel && cpuReq.ea < BASE_EA
        |=> !cpuRsp.hit && cpuRsp.rdata == 16'h0000)
        else $error("access outside RAM decoded");

    // A stored word reads back on the next access
    write_read_a: assert property (
        cpuHit && cpuReq.write && !cpuReq.isByte
        ##1 cpuHit && !cpuReq.write && !cpuReq.isByte
            && cpuIdx == $past(cpuIdx) && !$past(dmaReq.sel)
        |=> cpuRsp.rdata == $past(cpuReq.wdata, 2))
        else $error("stored value not read back");

    // Both ports are served in the same cycle
    parallel_read_a: assert property (
        cpuReq.sel && !cpuReq.write && dmaReq.sel && !dmaReq.write
        |=> cpuRsp.valid && dmaRsp.valid)
        else $error("ports not served together");

    // Main scenarios to be seen at least once
    collide_c: cover property (collide);
    both_rd_c: cover property (cpuRsp.valid && dmaRsp.valid);
    dma_wr_c:  cover property (dmaHit && dmaReq.write);
    byte_wr_c: cover property (cpuHit && cpuReq.write && cpuReq.isByte);
    outside_c: cover property (cpuRsp.valid && !cpuRsp.hit);

endmodule // dpr_ram

// *** shared/dpr_pkg.sv ***
// Package of constants and carrier types for the dual-port data RAM
// Functional notes
// - 2 KB RAM ending at Y space top
// - CPU and DMA ports access same cycle
// - DMA traffic never stalls the CPU
// - CPU write wins same-location write collision
// - DMA port both reads and writes RAM
// - Plain read/write storage without DMA use
// - Two byte lanes, LSB selects byte write
package dpr_pkg;

    // Size of the RAM in bytes and the data-space address width
    localparam int unsigned DPR_RAM_BYTES  = 2048;
    localparam int unsigned DPR_EA_WIDTH   = 16;
    localparam int unsigned DPR_DATA_WIDTH = 16;
    // Top of the 64 KB data space; RAM ends here
    localparam logic [16:0] DPR_SPACE_TOP  = 17'h10000;
    localparam logic [15:0] DPR_DATA_RESET = 16'h0000;

    // One access request from either port
    typedef struct packed {
        logic        sel;     // Request valid this cycle
        logic        write;   // 1 write, 0 read
        logic        isByte;  // Byte access selected by ea[0]
        logic [15:0] ea;      // Byte effective address
        logic [15:0] wdata;   // Write data, byte in low lane
    } dpr_req_type;

    // Answer returned one cycle after a request
    typedef struct packed {
        logic        valid;   // Read data valid
        logic        hit;     // Address fell inside the RAM
        logic [15:0] rdata;   // Read data
    } dpr_rsp_type;

endpackage

// *** sim/dpr_dma_model.sv ***
// DMA controller model issuing random reads and writes on the DMA port
module dpr_dma_model
    import dpr_pkg::*;
(
    input  wire logic  ref_clk,
    input  wire logic  en,
    output dpr_req_type dmaReq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] e;

    ////////////////////////////////////////////////////////////////////////
    // New request after every falling edge; fetch and deposit both used
    initial dmaReq = '0;
    always @(negedge ref_clk) begin
        e = $urandom;
        dmaReq.sel    <= en & e[0];
        dmaReq.write  <= e[1];
        dmaReq.isByte <= e[2];
        dmaReq.ea     <= (e[7:3] == 5'h00) ? 16'hFFBE : {10'h3FF, e[13:8]};
        dmaReq.wdata  <= e[31:16];
    end
endmodule // dpr_dma_model

// *** sim/tb_dual_port_dma_ram.sv ***
// Random self-checking bench for the dual-port data RAM
module tb_dual_port_dma_ram
    import dpr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic        dmaEn   = 1'b0;
    logic        collide;
    logic        expCol;
    dpr_req_type cpuReq  = '0;
    dpr_req_type dmaReq;
    dpr_rsp_type cpuRsp, dmaRsp, expC, expD;
    logic [7:0]  mem [64];
    int          failures = 0;
    int          checked  = 0;
    logic [31:0] e;

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and DMA side
    always #2 ref_clk = ~ref_clk;
    dpr_ram #(.RAM_BYTES(64), .BASE_EA(16'hFFC0)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .cpuReq(cpuReq),
        .dmaReq(dmaReq), .cpuRsp(cpuRsp), .dmaRsp(dmaRsp),
        .collide(collide));
    dpr_dma_model u_dma (.ref_clk(ref_clk), .en(dmaEn), .dmaReq(dmaReq));

    ////////////////////////////////////////////////////////////////////////
    // Reference model of the byte lanes
    function automatic dpr_rsp_type rd(dpr_req_type r);
        dpr_rsp_type s;
        s = '0;
        s.valid = r.sel & ~r.write;
        if (r.ea >= 16'hFFC0) begin
            s.hit   = 1'b1;
            s.rdata = r.isByte ? {8'h00, mem[r.ea[5:0]]}
                : {mem[{r.ea[5:1], 1'b1}], mem[{r.ea[5:1], 1'b0}]};
        end
        return s;
    endfunction

    function automatic logic [1:0] ln(dpr_req_type r);
        if (!(r.sel && r.write && r.ea >= 16'hFFC0)) return 2'h0;
        return r.isByte ? (r.ea[0] ? 2'h2 : 2'h1) : 2'h3;
    endfunction

    task automatic put(dpr_req_type r, logic [1:0] l);
        if (l[0]) mem[{r.ea[5:1], 1'b0}] = r.wdata[7:0];
        if (l[1]) mem[{r.ea[5:1], 1'b1}] = r.isByte ? r.wdata[7:0]
                                                      : r.wdata[15:8];
    endtask

    // Predict answers, then apply writes with the CPU lane winning
    task automatic step();
        logic [1:0] lc, ld;
        expC = rd(cpuReq);
        expD = rd(dmaReq);
        lc = ln(cpuReq);
        ld = ln(dmaReq);
        expCol = (cpuReq.ea[15:1] == dmaReq.ea[15:1]) && |(lc & ld);
        if (cpuReq.ea[15:1] == dmaReq.ea[15:1]) ld = ld & ~lc;
        put(dmaReq, ld);
        put(cpuReq, lc);
        // Held in reset at this edge: nothing taken, RAM cleared
        if (!resetn) begin
            for (int k = 0; k < 64; k++) mem[k] = 8'h00;
            expC   = '0;
            expD   = '0;
            expCol = 1'b0;
        end
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic cmp(dpr_rsp_type s, dpr_rsp_type x);
        check(16'(s.valid), 16'(x.valid));
        if (x.valid) check(16'(s.hit), 16'(x.hit));
        if (x.valid) check(s.rdata, x.rdata);
    endtask

    task automatic end_of_test();
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: random traffic, every fourth CPU access aimed at DMA
    initial begin
        void'($urandom(32'h769F));
        for (int k = 0; k < 64; k++) mem[k] = 8'h00;
        repeat (3) @(negedge ref_clk);
        resetn = 1'b1;
        // Enable after this edge so the model's first request is predicted
        #1 dmaEn = 1'b1;
        for (int i = 0; i < 3000; i++) begin
            @(negedge ref_clk);
            if (i > 0) cmp(cpuRsp, expC);
            if (i > 0) cmp(dmaRsp, expD);
            if (i > 0)
                check(16'(collide), 16'(expCol));
            // One-cycle reset in mid-run; the RAM must read back as zero
            resetn = (i != 1500);
            #1;
            e = $urandom;
            cpuReq = '{sel: e[0], write: e[1], isByte: e[2],
                ea: (e[7:3] == 5'h00) ? 16'hF7FE : {10'h3FF, e[13:8]},
                wdata: e[31:16]};
            if (i % 4 == 0) cpuReq.ea = dmaReq.ea;
            @(posedge ref_clk);
            step();
        end
        end_of_test();
    end

    // Watchdog: 3000 cycles of 4 ns take 12 us, so 20 us means a hang
    initial begin
        #20000;
        failures++;
        end_of_test();
    end
endmodule // tb_dual_port_dma_ram
